/* logic/pid_trim_pkg.sv */
// Purpose: Shared constants and carriers of the set-point trim block
// Assumes: 200 MHz control clock, 12-bit converter codes
// Notes: Percent values are signed, 0x4000 = 100 %; gains 1.0 = 0x1000
package pid_trim_pkg;

	localparam int CLK_MHZ = 200;
	localparam int UPDATE_PERIOD_US = 1000;
	localparam int UPDATE_CYCLES = UPDATE_PERIOD_US * CLK_MHZ;
	localparam int FRAC_BITS = 12;
	localparam int ADC_W = 12;

	localparam logic [15:0] UNITY = 16'h1000;
	localparam logic [15:0] GAIN_MAX = 16'h4000;
	localparam logic signed [15:0] PCT_FULL = 16'sh4000;
	localparam logic signed [15:0] PCT_NEG = 16'shc000;

	localparam logic [15:0] KP_RST = 16'h1000;
	localparam logic [15:0] KI_RST = 16'h0800;
	localparam logic [15:0] KD_RST = 16'h0000;
	localparam logic [15:0] HI_RST = 16'h4000;
	localparam logic [15:0] LO_RST = 16'hc000;
	localparam logic [15:0] OUT_RST = 16'h1000;

	// Live-zero code of the 4-20 mA range and the gain above it
	localparam logic [ADC_W-1:0] LIVE_ZERO = 12'h333;
	localparam logic [15:0] LIVE_GAIN = 16'h0005;

	localparam logic signed [17:0] SUM_MAX = 18'sh03fff;
	localparam logic signed [17:0] SUM_MIN = 18'sh3c000;
	localparam logic signed [15:0] SAT_MAX = 16'sh7fff;
	localparam logic signed [15:0] SAT_MIN = 16'sh8000;

	typedef enum logic [1:0] {
		MODE_0_20MA,
		MODE_4_20MA,
		MODE_0_10V
	} ain_mode_t;

	localparam logic [1:0] MODE_BAD = 2'h3;

	typedef struct packed {
		ain_mode_t freq;
		ain_mode_t sp;
		ain_mode_t fb;
	} ain_modes_t;

	localparam ain_modes_t MODES_RST = '{MODE_0_10V, MODE_0_10V, MODE_0_10V};

	typedef struct packed {
		logic [15:0] kp;
		logic [15:0] ki;
		logic [15:0] kd;
		logic [15:0] hi;
		logic [15:0] lo;
		logic [15:0] out_scale;
		logic [15:0] sp_scale;
		logic [15:0] fb_scale;
	} cfg_t;

	localparam cfg_t CFG_RST = '{KP_RST, KI_RST, KD_RST, HI_RST, LO_RST,
		OUT_RST, UNITY, UNITY};

	typedef struct packed {
		logic signed [15:0] pre_ramp;
		logic signed [15:0] post_ramp;
		logic signed [15:0] active_current;
	} mon_t;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODES = 8'h04;
	localparam logic [7:0] OFS_KP = 8'h08;
	localparam logic [7:0] OFS_KI = 8'h0c;
	localparam logic [7:0] OFS_KD = 8'h10;
	localparam logic [7:0] OFS_HI = 8'h14;
	localparam logic [7:0] OFS_LO = 8'h18;
	localparam logic [7:0] OFS_OUT = 8'h1c;
	localparam logic [7:0] OFS_SP_SCALE = 8'h20;
	localparam logic [7:0] OFS_FB_SCALE = 8'h24;
	localparam logic [7:0] OFS_FREQ = 8'h28;
	localparam logic [7:0] OFS_SP_RAW = 8'h2c;
	localparam logic [7:0] OFS_FB_RAW = 8'h30;
	localparam logic [7:0] OFS_SP_SCALED = 8'h34;
	localparam logic [7:0] OFS_FB_SCALED = 8'h38;
	localparam logic [7:0] OFS_PRE_RAMP = 8'h3c;
	localparam logic [7:0] OFS_POST_RAMP = 8'h40;
	localparam logic [7:0] OFS_ACTIVE_I = 8'h44;
	localparam logic [7:0] OFS_DEMAND = 8'h48;
	localparam logic [7:0] OFS_CORR = 8'h4c;

endpackage

/* logic/scale_sat.sv */
// Purpose: Registered signed-by-unsigned fixed point scaler
// Assumes: factor has FRAC_BITS fraction bits
// Notes: Result saturates to the signed 16-bit range
`timescale 1ns/1ps
module scale_sat (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic signed [15:0] value,
	input wire logic [15:0] factor,
	output logic signed [15:0] scaled
);

	logic signed [32:0] product;
	logic signed [32:0] shifted;
	logic signed [15:0] clipped;

	always_comb begin
		product = value * $signed({1'b0, factor});
		shifted = product >>> pid_trim_pkg::FRAC_BITS;
		if (shifted > 33'(pid_trim_pkg::SAT_MAX)) begin
			clipped = pid_trim_pkg::SAT_MAX;
		end else if (shifted < 33'(pid_trim_pkg::SAT_MIN)) begin
			clipped = pid_trim_pkg::SAT_MIN;
		end else begin
			clipped = shifted[15:0];
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			scaled <= '0;
		end else begin
			scaled <= clipped;
		end
	end

endmodule

/* logic/pid_setpoint_trim.sv */
// Purpose: Set-point PID trim added to the drive frequency reference
// Assumes: Converter codes arrive on this clock; contact is a raw pin
// Notes: Registers reached over a classic Wishbone slave
//
// How it works
// - Frequency control unless loop contact closed
// - Set-point and feedback scaled independently
// - Error = scaled set-point minus feedback, limited, scaled
// - Limiter clamps signed error between two bounds
// - Correction added to frequency reference
// - Input scale factors reset to unity
// - High limit defaults 100 %, range 0..100 %
// - Low limit defaults -100 %, range +-100 %
// - Output scale defaults 1, range 0..4
// - Gains 0..4, defaults 1, 0.5, 0
// - Each analog input has range selector
// - Inputs and scaled values readable
// - Ramp and current monitors ignore writes
// - Inputs map to demand, set-point, feedback
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module pid_setpoint_trim #(
	parameter int UPDATE_CYCLES = pid_trim_pkg::UPDATE_CYCLES
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic loop_enable_contact,
	input wire logic [11:0] freq_ref_input,
	input wire logic [11:0] setpoint_input,
	input wire logic [11:0] process_feedback_input,
	input wire pid_trim_pkg::mon_t drive_monitor,
	output pid_trim_pkg::ain_modes_t ain_mode_sel,
	output logic signed [15:0] demand_out,
	output logic loop_active
);

	pid_trim_pkg::cfg_t cfg_reg;
	logic contact_meta_reg;
	logic contact_sync_reg;
	logic [31:0] tick_cnt_reg;
	logic tick_reg;
	logic tick_d1_reg;
	logic signed [15:0] freq_pct_reg;
	logic signed [15:0] sp_pct_reg;
	logic signed [15:0] fb_pct_reg;
	logic signed [15:0] sp_scaled;
	logic signed [15:0] fb_scaled;
	logic signed [15:0] err_lim_reg;
	logic signed [15:0] err_prev_reg;
	logic signed [15:0] integ_reg;
	logic signed [15:0] sum_reg;
	logic signed [15:0] p_term;
	logic signed [15:0] i_step;
	logic signed [15:0] d_term;
	logic signed [15:0] corr;
	logic signed [15:0] err_diff;
	logic signed [15:0] integ_next;
	logic signed [16:0] err_full;
	logic [7:0] reg_ofs;
	logic wr_fire;
	logic load_defaults;
	logic [31:0] rd_data;

	// Converter code to percent for the chosen range
	function automatic logic signed [15:0] to_pct(
		input logic [11:0] code,
		input pid_trim_pkg::ain_mode_t mode
	);
		logic [15:0] above;
		above = {4'h0, code} - {4'h0, pid_trim_pkg::LIVE_ZERO};
		to_pct = {2'b00, code, 2'b00};
		if (mode == pid_trim_pkg::MODE_4_20MA) begin
			if (code < pid_trim_pkg::LIVE_ZERO) begin
				to_pct = '0;
			end else begin
				to_pct = above * pid_trim_pkg::LIVE_GAIN;
			end
		end
	endfunction

	function automatic logic signed [15:0] clamp_pct(
		input logic signed [17:0] v
	);
		if (v > pid_trim_pkg::SUM_MAX) begin
			clamp_pct = pid_trim_pkg::PCT_FULL;
		end else if (v < pid_trim_pkg::SUM_MIN) begin
			clamp_pct = pid_trim_pkg::PCT_NEG;
		end else begin
			clamp_pct = v[15:0];
		end
	endfunction

	function automatic logic [15:0] clip_gain(input logic [15:0] v);
		clip_gain = (v > pid_trim_pkg::GAIN_MAX) ? pid_trim_pkg::GAIN_MAX : v;
	endfunction

	function automatic logic [15:0] clip_hi(input logic [15:0] v);
		if (v[15]) begin
			clip_hi = '0;
		end else if (v > pid_trim_pkg::PCT_FULL) begin
			clip_hi = pid_trim_pkg::PCT_FULL;
		end else begin
			clip_hi = v;
		end
	endfunction

	function automatic logic [15:0] clip_lo(input logic [15:0] v);
		clip_lo = clamp_pct(18'($signed(v)));
	endfunction

	// Bus decode
	assign reg_ofs = {wb_adr_i[7:2], 2'b00};
	assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
		&& (wb_sel_i[1:0] == 2'b11);
	assign load_defaults = wr_fire && (reg_ofs == pid_trim_pkg::OFS_CTRL)
		&& wb_dat_i[0];

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= rd_data;
		end
	end

	always_comb begin
		rd_data = '0;
		unique case (reg_ofs)
			pid_trim_pkg::OFS_CTRL: rd_data = {30'h0, contact_sync_reg,
				loop_active};
			pid_trim_pkg::OFS_MODES: rd_data = {26'h0, ain_mode_sel.fb,
				ain_mode_sel.sp, ain_mode_sel.freq};
			pid_trim_pkg::OFS_KP: rd_data = {16'h0, cfg_reg.kp};
			pid_trim_pkg::OFS_KI: rd_data = {16'h0, cfg_reg.ki};
			pid_trim_pkg::OFS_KD: rd_data = {16'h0, cfg_reg.kd};
			pid_trim_pkg::OFS_HI: rd_data = {16'h0, cfg_reg.hi};
			pid_trim_pkg::OFS_LO: rd_data = {16'h0, cfg_reg.lo};
			pid_trim_pkg::OFS_OUT: rd_data = {16'h0, cfg_reg.out_scale};
			pid_trim_pkg::OFS_SP_SCALE: rd_data = {16'h0, cfg_reg.sp_scale};
			pid_trim_pkg::OFS_FB_SCALE: rd_data = {16'h0, cfg_reg.fb_scale};
			pid_trim_pkg::OFS_FREQ: rd_data = {16'h0, freq_pct_reg};
			pid_trim_pkg::OFS_SP_RAW: rd_data = {16'h0, sp_pct_reg};
			pid_trim_pkg::OFS_FB_RAW: rd_data = {16'h0, fb_pct_reg};
			pid_trim_pkg::OFS_SP_SCALED: rd_data = {16'h0, sp_scaled};
			pid_trim_pkg::OFS_FB_SCALED: rd_data = {16'h0, fb_scaled};
			pid_trim_pkg::OFS_PRE_RAMP:
				rd_data = {16'h0, drive_monitor.pre_ramp};
			pid_trim_pkg::OFS_POST_RAMP:
				rd_data = {16'h0, drive_monitor.post_ramp};
			pid_trim_pkg::OFS_ACTIVE_I:
				rd_data = {16'h0, drive_monitor.active_current};
			pid_trim_pkg::OFS_DEMAND: rd_data = {16'h0, demand_out};
			pid_trim_pkg::OFS_CORR: rd_data = {16'h0, corr};
			default: rd_data = '0;
		endcase
	end

	// Settings; monitor offsets have no store so writes fall through
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cfg_reg <= pid_trim_pkg::CFG_RST;
		end else if (load_defaults) begin
			cfg_reg <= pid_trim_pkg::CFG_RST;
		end else if (wr_fire) begin
			unique case (reg_ofs)
				pid_trim_pkg::OFS_KP:
					cfg_reg.kp <= clip_gain(wb_dat_i[15:0]);
				pid_trim_pkg::OFS_KI:
					cfg_reg.ki <= clip_gain(wb_dat_i[15:0]);
				pid_trim_pkg::OFS_KD:
					cfg_reg.kd <= clip_gain(wb_dat_i[15:0]);
				pid_trim_pkg::OFS_HI:
					cfg_reg.hi <= clip_hi(wb_dat_i[15:0]);
				pid_trim_pkg::OFS_LO:
					cfg_reg.lo <= clip_lo(wb_dat_i[15:0]);
				pid_trim_pkg::OFS_OUT:
					cfg_reg.out_scale <= clip_gain(wb_dat_i[15:0]);
				pid_trim_pkg::OFS_SP_SCALE:
					cfg_reg.sp_scale <= clip_gain(wb_dat_i[15:0]);
				pid_trim_pkg::OFS_FB_SCALE:
					cfg_reg.fb_scale <= clip_gain(wb_dat_i[15:0]);
				default: cfg_reg <= cfg_reg;
			endcase
		end
	end

	// Range selectors; the unused code leaves a field unchanged
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ain_mode_sel <= pid_trim_pkg::MODES_RST;
		end else if (load_defaults) begin
			ain_mode_sel <= pid_trim_pkg::MODES_RST;
		end else if (wr_fire && reg_ofs == pid_trim_pkg::OFS_MODES) begin
			if (wb_dat_i[1:0] != pid_trim_pkg::MODE_BAD) begin
				ain_mode_sel.freq <= pid_trim_pkg::ain_mode_t'(wb_dat_i[1:0]);
			end
			if (wb_dat_i[3:2] != pid_trim_pkg::MODE_BAD) begin
				ain_mode_sel.sp <= pid_trim_pkg::ain_mode_t'(wb_dat_i[3:2]);
			end
			if (wb_dat_i[5:4] != pid_trim_pkg::MODE_BAD) begin
				ain_mode_sel.fb <= pid_trim_pkg::ain_mode_t'(wb_dat_i[5:4]);
			end
		end
	end

	// Loop contact synchroniser and mode flag
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			contact_meta_reg <= 1'b0;
			contact_sync_reg <= 1'b0;
			loop_active <= 1'b0;
		end else begin
			contact_meta_reg <= loop_enable_contact;
			contact_sync_reg <= contact_meta_reg;
			loop_active <= contact_sync_reg;
		end
	end

	// Control update tick
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b0;
			tick_d1_reg <= 1'b0;
		end else begin
			tick_d1_reg <= tick_reg;
			if (tick_cnt_reg == 32'(UPDATE_CYCLES - 1)) begin
				tick_cnt_reg <= '0;
				tick_reg <= 1'b1;
			end else begin
				tick_cnt_reg <= tick_cnt_reg + 32'h1;
				tick_reg <= 1'b0;
			end
		end
	end

	// Input conditioning
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			freq_pct_reg <= '0;
			sp_pct_reg <= '0;
			fb_pct_reg <= '0;
		end else begin
			freq_pct_reg <= to_pct(freq_ref_input, ain_mode_sel.freq);
			sp_pct_reg <= to_pct(setpoint_input, ain_mode_sel.sp);
			fb_pct_reg <= to_pct(process_feedback_input,
				ain_mode_sel.fb);
		end
	end

	scale_sat u_sp_scale (
		.clock(clock),
		.rst_b(rst_b),
		.value(sp_pct_reg),
		.factor(cfg_reg.sp_scale),
		.scaled(sp_scaled)
	);

	scale_sat u_fb_scale (
		.clock(clock),
		.rst_b(rst_b),
		.value(fb_pct_reg),
		.factor(cfg_reg.fb_scale),
		.scaled(fb_scaled)
	);

	// Error and limiter; with crossed bounds an error above the high bound gives the high bound, any other gives the low
	assign err_full = 17'(sp_scaled) - 17'(fb_scaled);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			err_lim_reg <= '0;
		end else if (err_full > 17'($signed(cfg_reg.hi))) begin
			err_lim_reg <= cfg_reg.hi;
		end else if (err_full < 17'($signed(cfg_reg.lo))) begin
			err_lim_reg <= cfg_reg.lo;
		end else begin
			err_lim_reg <= err_full[15:0];
		end
	end

	assign err_diff = clamp_pct(18'(err_lim_reg) - 18'(err_prev_reg));

	scale_sat u_p_term (
		.clock(clock),
		.rst_b(rst_b),
		.value(err_lim_reg),
		.factor(cfg_reg.kp),
		.scaled(p_term)
	);

	scale_sat u_i_step (
		.clock(clock),
		.rst_b(rst_b),
		.value(err_lim_reg),
		.factor(cfg_reg.ki),
		.scaled(i_step)
	);

	scale_sat u_d_term (
		.clock(clock),
		.rst_b(rst_b),
		.value(err_diff),
		.factor(cfg_reg.kd),
		.scaled(d_term)
	);

	assign integ_next = clamp_pct(18'(integ_reg) + 18'(i_step));

	// Terms latched once per update; integral cleared outside the loop
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			err_prev_reg <= '0;
			integ_reg <= '0;
			sum_reg <= '0;
		end else if (!loop_active) begin
			err_prev_reg <= '0;
			integ_reg <= '0;
			sum_reg <= '0;
		end else begin
			if (tick_reg) begin
				err_prev_reg <= err_lim_reg;
			end
			if (tick_d1_reg) begin
				integ_reg <= integ_next;
				sum_reg <= clamp_pct(18'(p_term) + 18'(integ_next)
					+ 18'(d_term));
			end
		end
	end

	scale_sat u_out_scale (
		.clock(clock),
		.rst_b(rst_b),
		.value(sum_reg),
		.factor(cfg_reg.out_scale),
		.scaled(corr)
	);

	// Demand to the drive
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			demand_out <= '0;
		end else if (loop_active) begin
			demand_out <= clamp_pct(18'(freq_pct_reg) + 18'(corr));
		end else begin
			demand_out <= freq_pct_reg;
		end
	end

endmodule

/* bench/pid_trim_model.sv */
// Purpose: Far side: loop contact, transducer, set-point pot, drive monitor
// Assumes: Converter codes settle on the control clock
// Notes: Levels follow bench commands one edge later
`timescale 1ns/1ps
module pid_trim_model (
	input wire logic clock,
	input wire logic close_cmd,
	input wire logic [11:0] freq_cmd,
	input wire logic [11:0] sp_cmd,
	input wire logic [11:0] fb_cmd,
	output logic loop_enable_contact,
	output logic [11:0] freq_ref_input,
	output logic [11:0] setpoint_input,
	output logic [11:0] process_feedback_input,
	output pid_trim_pkg::mon_t drive_monitor
);
	// Reference source stays at setting zero; nothing here selects it
	assign drive_monitor = '{16'sh1234, 16'sh0567, 16'shff77};
	initial begin
		loop_enable_contact = 1'b0;
		freq_ref_input = 12'h000;
		setpoint_input = 12'h000;
		process_feedback_input = 12'h000;
	end
	always @(posedge clock) begin
		loop_enable_contact <= close_cmd;
		freq_ref_input <= freq_cmd;
		setpoint_input <= sp_cmd;
		process_feedback_input <= fb_cmd;
	end
endmodule

/* bench/pid_setpoint_trim_chk.sv */
// Purpose: Port-level checks of the set-point trim block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound into every instance of the block
`timescale 1ns/1ps
module pid_setpoint_trim_chk #(
	parameter int UPDATE_CYCLES = 16
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic loop_enable_contact,
	input wire logic [11:0] freq_ref_input,
	input wire pid_trim_pkg::ain_modes_t ain_mode_sel,
	input wire logic signed [15:0] demand_out,
	input wire logic loop_active
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	sequence req_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence freq_quiet;
		(!loop_active && $stable(freq_ref_input) && $stable(ain_mode_sel)
			&& ain_mode_sel.freq == pid_trim_pkg::MODE_0_10V) [*4];
	endsequence
	chk_ack_follows_req: assert property (
		req_taken |=> wb_ack_o) else $error("ack missing");
	chk_ack_one_cycle: assert property (
		wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	chk_read_upper_zero: assert property (
		wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper bits");
	chk_contact_closes: assert property (
		loop_enable_contact [*3] |=> loop_active) else $error("loop not on");
	chk_contact_opens: assert property (
		!loop_enable_contact [*3] |=> !loop_active) else $error("loop not off");
	chk_freq_demand: assert property (
		freq_quiet |-> demand_out == $signed({2'b00, freq_ref_input, 2'b00}))
		else $error("frequency demand wrong");
	chk_demand_range: assert property (
		demand_out <= pid_trim_pkg::PCT_FULL
		&& demand_out >= pid_trim_pkg::PCT_NEG) else $error("demand range");
	chk_mode_by_write: assert property (
		!$stable(ain_mode_sel) |-> $past(wb_ack_o && wb_we_i))
		else $error("mode moved alone");
	chk_mode_legal: assert property (
		ain_mode_sel.freq != pid_trim_pkg::MODE_BAD
		&& ain_mode_sel.sp != pid_trim_pkg::MODE_BAD
		&& ain_mode_sel.fb != pid_trim_pkg::MODE_BAD) else $error("bad mode");
endmodule

bind pid_setpoint_trim pid_setpoint_trim_chk #(
	.UPDATE_CYCLES(UPDATE_CYCLES)) i_chk (.*);

/* bench/pid_setpoint_trim_bench.sv */
// Purpose: Register and loop scenarios for the set-point trim block
// Assumes: Short update period of 16 cycles
// Notes: Percent 0x4000 = 100 %, codes scale by four in 0-10 V
`timescale 1ns/1ps
module pid_setpoint_trim_bench;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, close_cmd = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
	logic [11:0] freq_cmd = 12'h100, sp_cmd = 12'h200, fb_cmd = 12'h180;
	logic [11:0] freq_ref_input, setpoint_input, process_feedback_input;
	logic wb_ack_o, loop_active, loop_enable_contact;
	logic signed [15:0] demand_out;
	pid_trim_pkg::ain_modes_t ain_mode_sel;
	pid_trim_pkg::mon_t drive_monitor;
	int error_cnt = 0, check_count = 0;
	always #2.5 clock = ~clock;
	pid_trim_model i_far (.clock(clock), .close_cmd(close_cmd),
		.freq_cmd(freq_cmd), .sp_cmd(sp_cmd), .fb_cmd(fb_cmd),
		.loop_enable_contact(loop_enable_contact),
		.freq_ref_input(freq_ref_input), .setpoint_input(setpoint_input),
		.process_feedback_input(process_feedback_input),
		.drive_monitor(drive_monitor));
	pid_setpoint_trim #(.UPDATE_CYCLES(16)) i_dut (.clock(clock),
		.rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.loop_enable_contact(loop_enable_contact),
		.freq_ref_input(freq_ref_input), .setpoint_input(setpoint_input),
		.process_feedback_input(process_feedback_input),
		.drive_monitor(drive_monitor), .ain_mode_sel(ain_mode_sel),
		.demand_out(demand_out), .loop_active(loop_active));
	task automatic results;
		if (error_cnt == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wb(input logic [7:0] a, input logic w,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rdat = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			error_cnt++;
			results();
		end
		@(posedge clock);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		wb(a, 1'b0, 32'h0, 4'hf);
		chk(rdat, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		wb(a, 1'b1, {16'h0, d}, 4'hf);
		repeat (4) @(posedge clock);
	endtask
	task automatic dm(input int n, input logic [15:0] exp);
		repeat (n) @(posedge clock);
		chk({16'h0, demand_out}, {16'h0, exp});
	endtask
	initial begin
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		rc(pid_trim_pkg::OFS_KP, 32'h1000);
		rc(pid_trim_pkg::OFS_KI, 32'h0800);
		rc(pid_trim_pkg::OFS_KD, 32'h0000);
		rc(pid_trim_pkg::OFS_HI, 32'h4000);
		rc(pid_trim_pkg::OFS_LO, 32'h0000c000);
		rc(pid_trim_pkg::OFS_OUT, 32'h1000);
		rc(pid_trim_pkg::OFS_SP_SCALE, 32'h1000);
		rc(pid_trim_pkg::OFS_FB_SCALE, 32'h1000);
		rc(pid_trim_pkg::OFS_MODES, 32'h2a);
		rc(8'h50, 32'h0);
		rc(pid_trim_pkg::OFS_FREQ, 32'h400);
		rc(pid_trim_pkg::OFS_SP_RAW, 32'h800);
		rc(pid_trim_pkg::OFS_FB_RAW, 32'h600);
		rc(pid_trim_pkg::OFS_FB_SCALED, 32'h600);
		dm(1, 16'h0400);
		wr(pid_trim_pkg::OFS_PRE_RAMP, 16'h0000);
		rc(pid_trim_pkg::OFS_PRE_RAMP, 32'h1234);
		rc(pid_trim_pkg::OFS_POST_RAMP, 32'h0567);
		rc(pid_trim_pkg::OFS_ACTIVE_I, 32'hff77);
		wr(pid_trim_pkg::OFS_SP_SCALE, 16'h2000);
		rc(pid_trim_pkg::OFS_SP_SCALED, 32'h1000);
		rc(pid_trim_pkg::OFS_FB_SCALED, 32'h600);
		wr(pid_trim_pkg::OFS_KP, 16'h5000);
		rc(pid_trim_pkg::OFS_KP, 32'h4000);
		wr(pid_trim_pkg::OFS_HI, 16'h8000);
		rc(pid_trim_pkg::OFS_HI, 32'h0);
		wr(pid_trim_pkg::OFS_LO, 16'h8000);
		rc(pid_trim_pkg::OFS_LO, 32'hc000);
		wr(pid_trim_pkg::OFS_OUT, 16'h7000);
		rc(pid_trim_pkg::OFS_OUT, 32'h4000);
		wb(pid_trim_pkg::OFS_KD, 1'b1, 32'h0123, 4'h1);
		rc(pid_trim_pkg::OFS_KD, 32'h0);
		wr(pid_trim_pkg::OFS_MODES, 16'h002b);
		rc(pid_trim_pkg::OFS_MODES, 32'h2a);
		wr(pid_trim_pkg::OFS_CTRL, 16'h0001);
		rc(pid_trim_pkg::OFS_KP, 32'h1000);
		wr(pid_trim_pkg::OFS_MODES, 16'h0024);
		chk({26'h0, ain_mode_sel.fb, ain_mode_sel.sp,
			ain_mode_sel.freq}, 32'h24);
		sp_cmd <= 12'h433;
		// Model, then the percent register, each take one edge
		repeat (3) @(posedge clock);
		rc(pid_trim_pkg::OFS_SP_RAW, 32'h500);
		sp_cmd <= 12'h200;
		repeat (3) @(posedge clock);
		rc(pid_trim_pkg::OFS_SP_RAW, 32'h0);
		wr(pid_trim_pkg::OFS_MODES, 16'h002a);
		wr(pid_trim_pkg::OFS_KI, 16'h0000);
		close_cmd <= 1'b1;
		dm(80, 16'h0600);
		rc(pid_trim_pkg::OFS_CORR, 32'h200);
		rc(pid_trim_pkg::OFS_CTRL, 32'h3);
		wr(pid_trim_pkg::OFS_HI, 16'h0100);
		dm(40, 16'h0500);
		wr(pid_trim_pkg::OFS_OUT, 16'h2000);
		dm(40, 16'h0600);
		wr(pid_trim_pkg::OFS_LO, 16'hff00);
		fb_cmd <= 12'h280;
		dm(60, 16'h0200);
		wr(pid_trim_pkg::OFS_OUT, 16'h1000);
		wr(pid_trim_pkg::OFS_KP, 16'h0000);
		wr(pid_trim_pkg::OFS_KI, 16'h1000);
		dm(1400, 16'hc400);
		close_cmd <= 1'b0;
		dm(30, 16'h0400);
		close_cmd <= 1'b1;
		repeat (40) @(posedge clock);
		chk({31'h0, demand_out === 16'hc400}, 32'h0);
		results();
	end
endmodule
